// *** hdl/indwd_regs.sv ***
// Independent watchdog top: AXI4-Lite register slave around the counting core
// Notes on behaviour
// - Half-word and word accesses work on every register, except that a key write counts only with both low byte lanes set.
// - Key field is write-only and always reads zero.
// - Running counter reaching zero without refresh raises system reset.
// - Unlock key opens prescaler, reload and window for writes.
// - Start key starts the counter.
// - Prescaler select divides by 4,8,16,32,64, or 256 for the rest.
// - Prescaler changes only while its update flag is clear.
// - Prescaler read returns the active copy.
// - Refresh key loads the reload value into the counter.
// - Reload changes only while its update flag is clear.
// - Reload read returns the active copy.
// - Update flags set on write, clear when the update lands.
// - Refresh outside the window, or at zero, causes reset unless the window is 0xfff.
// - Window changes only while its update flag is clear.
// - Status kept in standby; key, reload, window reset by standby.
// - Counter starts from 0xfff after start.
// - Once started the watchdog cannot be stopped.
// - Any key other than unlock relocks the protected registers.
// - A window update reloads the counter.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module indwd_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic                        clk_i,
	input  wire logic                        resetn_i,
	input  wire logic                        standby_i,
	input  wire logic                        low_speed_oscillator_clock_i,
	input  wire logic [ADDR_W-1:0]           s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	output logic [1:0]                       s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]           s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic [31:0]                      s_axi_rdata_o,
	output logic [1:0]                       s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	output logic                             sys_reset_o,
	output logic                             running_o,
	output logic [indwd_pkg::CNT_W-1:0]      count_o
);
	import indwd_pkg::*;

	generate
		if (ADDR_W < 5)
		begin : g_bad_addr
			$error("ADDR_W must be at least 5");
		end
	endgenerate

	logic [ADDR_W-1:0]   awaddr_q;
	logic                aw_hold_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                w_hold_q;
	logic                wr_fire;
	logic [7:0]          wr_ofs;
	logic [7:0]          rd_ofs;
	logic                wr_mapped;
	logic                rd_mapped;
	logic                key_wr;
	logic [15:0]         key_val;
	logic                unlock_q;
	logic [NUM_UPD-1:0]  cfg_wr;
	indwd_cfg_s          cfg_wdata;
	indwd_cfg_s          active;
	logic [NUM_UPD-1:0]  pending;
	logic                core_running;
	logic [CNT_W-1:0]    core_count;
	logic                core_reset;
	logic [31:0]         rd_word;
	logic [31:0]         mrg_presc;
	logic [31:0]         mrg_reload;
	logic [31:0]         mrg_window;

	function automatic logic ofs_mapped(input logic [7:0] ofs);
		return (ofs == OFS_KEY) || (ofs == OFS_PRESCALE) || (ofs == OFS_RELOAD) ||
			(ofs == OFS_STATUS) || (ofs == OFS_WINDOW);
	endfunction : ofs_mapped

	assign wr_ofs    = 8'(awaddr_q);
	assign rd_ofs    = 8'(s_axi_araddr_i);
	assign wr_mapped = ofs_mapped(wr_ofs) && (awaddr_q[ADDR_W-1:0] == ADDR_W'(wr_ofs));
	assign rd_mapped = ofs_mapped(rd_ofs) && (s_axi_araddr_i == ADDR_W'(rd_ofs));
	assign wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid_o;

	// Write address channel
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			aw_hold_q       <= 1'b0;
			awaddr_q        <= '0;
			s_axi_awready_o <= 1'b1;
		end
		else if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			aw_hold_q       <= 1'b1;
			awaddr_q        <= s_axi_awaddr_i;
			s_axi_awready_o <= 1'b0;
		end
		else if (s_axi_bvalid_o && s_axi_bready_i)
		begin
			aw_hold_q       <= 1'b0;
			s_axi_awready_o <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			w_hold_q       <= 1'b0;
			wdata_q        <= '0;
			wstrb_q        <= '0;
			s_axi_wready_o <= 1'b1;
		end
		else if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			w_hold_q       <= 1'b1;
			wdata_q        <= s_axi_wdata_i;
			wstrb_q        <= s_axi_wstrb_i;
			s_axi_wready_o <= 1'b0;
		end
		else if (s_axi_bvalid_o && s_axi_bready_i)
		begin
			w_hold_q       <= 1'b0;
			s_axi_wready_o <= 1'b1;
		end
	end

	// Write response
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready_i)
		begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// key needs both low lanes, a half-word or word
	assign key_wr  = wr_fire && wr_mapped && (wr_ofs == OFS_KEY) && (wstrb_q[1:0] == 2'b11);
	assign key_val = wdata_q[15:0];

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			unlock_q <= 1'b0;
		else if (standby_i)
			unlock_q <= 1'b0;
		else if (key_wr)
			unlock_q <= (key_val == KEY_UNLOCK);
	end

	assign mrg_presc  = lane_merge({29'h0, active.presc}, wdata_q, wstrb_q);
	assign mrg_reload = lane_merge({20'h0, active.reload}, wdata_q, wstrb_q);
	assign mrg_window = lane_merge({20'h0, active.window}, wdata_q, wstrb_q);

	always_comb
	begin
		cfg_wdata.presc  = mrg_presc[PSC_W-1:0];
		cfg_wdata.reload = mrg_reload[CNT_W-1:0];
		cfg_wdata.window = mrg_window[CNT_W-1:0];
	end

	// writes dropped while locked or pending
	always_comb
	begin
		cfg_wr = '0;
		if (wr_fire && wr_mapped && unlock_q && (wstrb_q != 4'h0))
		begin
			if (wr_ofs == OFS_PRESCALE)
				cfg_wr[UPD_PRESC] = !pending[UPD_PRESC];
			else if (wr_ofs == OFS_RELOAD)
				cfg_wr[UPD_RELOAD] = !pending[UPD_RELOAD];
			else if (wr_ofs == OFS_WINDOW)
				cfg_wr[UPD_WINDOW] = !pending[UPD_WINDOW];
		end
	end

	indwd_core u_core (
		.clk_i                        (clk_i),
		.resetn_i                     (resetn_i),
		.standby_i                    (standby_i),
		.low_speed_oscillator_clock_i (low_speed_oscillator_clock_i),
		.start_i                      (key_wr && (key_val == KEY_START)),
		.refresh_i                    (key_wr && (key_val == KEY_REFRESH)),
		.cfg_wr_i                     (cfg_wr),
		.cfg_i                        (cfg_wdata),
		.active_o                     (active),
		.pending_o                    (pending),
		.running_o                    (core_running),
		.count_o                      (core_count),
		.sys_reset_o                  (core_reset)
	);

	// Read data selection
	always_comb
	begin
		rd_word = 32'h0;
		if (rd_ofs == OFS_KEY)
			rd_word = 32'h0;
		else if (rd_ofs == OFS_PRESCALE)
			rd_word = {29'h0, active.presc};
		else if (rd_ofs == OFS_RELOAD)
			rd_word = {20'h0, active.reload};
		else if (rd_ofs == OFS_STATUS)
			rd_word = {29'h0, pending};
		else if (rd_ofs == OFS_WINDOW)
			rd_word = {20'h0, active.window};
	end

	// Read channel
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_mapped ? rd_word : 32'h0;
			s_axi_rresp_o   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
		begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
		end
	end

	// Status outputs from flip-flops
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			sys_reset_o <= 1'b0;
			running_o   <= 1'b0;
			count_o     <= CNT_INIT;
		end
		else
		begin
			sys_reset_o <= core_reset;
			running_o   <= core_running;
			count_o     <= core_count;
		end
	end

endmodule : indwd_regs

// *** hdl/indwd_pkg.sv ***
// Shared constants, types and helpers for the independent watchdog
package indwd_pkg;

	localparam int          CNT_W        = 12;
	localparam int          PSC_W        = 3;
	localparam int          DIV_W        = 8;
	localparam int          UPD_W        = 3;
	localparam int          NUM_UPD      = 3;

	localparam logic [7:0]  OFS_KEY      = 8'h00;
	localparam logic [7:0]  OFS_PRESCALE = 8'h04;
	localparam logic [7:0]  OFS_RELOAD   = 8'h08;
	localparam logic [7:0]  OFS_STATUS   = 8'h0c;
	localparam logic [7:0]  OFS_WINDOW   = 8'h10;

	localparam logic [15:0] KEY_REFRESH  = 16'haaaa;
	localparam logic [15:0] KEY_UNLOCK   = 16'h5555;
	localparam logic [15:0] KEY_START    = 16'hcccc;

	localparam logic [CNT_W-1:0] CNT_INIT      = 12'hfff;
	localparam logic [CNT_W-1:0] RELOAD_RST    = 12'hfff;
	localparam logic [CNT_W-1:0] WINDOW_RST    = 12'hfff;
	localparam logic [CNT_W-1:0] WINDOW_OFF    = 12'hfff;
	localparam logic [PSC_W-1:0] PRESC_RST     = 3'h0;
	localparam logic [UPD_W-1:0] UPD_TICKS     = 3'h3;

	localparam int          UPD_PRESC    = 0;
	localparam int          UPD_RELOAD   = 1;
	localparam int          UPD_WINDOW   = 2;

	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef struct packed {
		logic [PSC_W-1:0] presc;
		logic [CNT_W-1:0] reload;
		logic [CNT_W-1:0] window;
	} indwd_cfg_s;

	// Terminal count of the prescaler for a divider select
	function automatic logic [DIV_W-1:0] presc_limit(input logic [PSC_W-1:0] sel);
		logic [DIV_W-1:0] lim;
		lim = 8'hff;
		case (sel)
			3'h0: lim = 8'h03;
			3'h1: lim = 8'h07;
			3'h2: lim = 8'h0f;
			3'h3: lim = 8'h1f;
			3'h4: lim = 8'h3f;
			default: lim = 8'hff;
		endcase
		return lim;
	endfunction : presc_limit

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction : lane_merge

endpackage : indwd_pkg

// *** hdl/indwd_core.sv ***
// Counting side of the independent watchdog: prescaler, down-counter, update pipes
`timescale 1ns/1ps
module indwd_core (
	input  wire logic                          clk_i,
	input  wire logic                          resetn_i,
	input  wire logic                          standby_i,
	input  wire logic                          low_speed_oscillator_clock_i,
	input  wire logic                          start_i,
	input  wire logic                          refresh_i,
	input  wire logic [indwd_pkg::NUM_UPD-1:0] cfg_wr_i,
	input  indwd_pkg::indwd_cfg_s              cfg_i,
	output indwd_pkg::indwd_cfg_s              active_o,
	output logic      [indwd_pkg::NUM_UPD-1:0] pending_o,
	output logic                               running_o,
	output logic      [indwd_pkg::CNT_W-1:0]   count_o,
	output logic                               sys_reset_o
);
	import indwd_pkg::*;

	logic                 osc_q;
	logic                 osc_tick;
	indwd_cfg_s           stage_q;
	logic [NUM_UPD-1:0]   pend_q;
	logic [UPD_W-1:0]     upd_cnt_q [NUM_UPD];
	logic [NUM_UPD-1:0]   upd_done;
	logic [DIV_W-1:0]     div_q;
	logic                 dec_tick;
	logic                 win_reload;
	logic                 refresh_bad;

	// low-speed clock sampled, one tick per rising edge
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			osc_q <= 1'b0;
		else
			osc_q <= low_speed_oscillator_clock_i;
	end
	assign osc_tick = low_speed_oscillator_clock_i & ~osc_q;

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			running_o <= 1'b0;
		else if (start_i)
			running_o <= 1'b1;
	end

	// pending flags, cleared after update ticks
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			pend_q <= '0;
			for (int i = 0; i < NUM_UPD; i++)
				upd_cnt_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_UPD; i++)
			begin
				if (cfg_wr_i[i] && !pend_q[i])
				begin
					pend_q[i]    <= 1'b1;
					upd_cnt_q[i] <= '0;
				end
				else if (pend_q[i] && osc_tick)
				begin
					if (upd_done[i])
						pend_q[i] <= 1'b0;
					upd_cnt_q[i] <= upd_cnt_q[i] + 3'h1;
				end
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < NUM_UPD; i++)
			upd_done[i] = pend_q[i] && osc_tick && (upd_cnt_q[i] == UPD_TICKS - 3'h1);
	end
	assign pending_o = pend_q;

	// staging taken only while not pending
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			stage_q <= '{presc: PRESC_RST, reload: RELOAD_RST, window: WINDOW_RST};
		else
		begin
			if (cfg_wr_i[UPD_PRESC] && !pend_q[UPD_PRESC])
				stage_q.presc <= cfg_i.presc;
			if (cfg_wr_i[UPD_RELOAD] && !pend_q[UPD_RELOAD])
				stage_q.reload <= cfg_i.reload;
			if (cfg_wr_i[UPD_WINDOW] && !pend_q[UPD_WINDOW])
				stage_q.window <= cfg_i.window;
		end
	end

	// standby returns reload and window to defaults
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			active_o <= '{presc: PRESC_RST, reload: RELOAD_RST, window: WINDOW_RST};
		else
		begin
			if (upd_done[UPD_PRESC])
				active_o.presc <= stage_q.presc;
			if (standby_i)
				active_o.reload <= RELOAD_RST;
			else if (upd_done[UPD_RELOAD])
				active_o.reload <= stage_q.reload;
			if (standby_i)
				active_o.window <= WINDOW_RST;
			else if (upd_done[UPD_WINDOW])
				active_o.window <= stage_q.window;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			div_q <= '0;
		else if (running_o && osc_tick)
		begin
			if (div_q >= presc_limit(active_o.presc))
				div_q <= '0;
			else
				div_q <= div_q + 8'h01;
		end
	end
	assign dec_tick = running_o && osc_tick && (div_q >= presc_limit(active_o.presc));

	assign win_reload = upd_done[UPD_WINDOW];
	assign refresh_bad = (active_o.window != WINDOW_OFF) &&
		((count_o >= active_o.window) || (count_o == '0));

	// refresh reloads, start value, count down
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			count_o <= CNT_INIT;
		else if ((refresh_i || win_reload) && running_o)
			count_o <= win_reload ? stage_q.reload : active_o.reload;
		else if (dec_tick && count_o != '0)
			count_o <= count_o - 12'h001;
	end

	// expiry or bad refresh resets system
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			sys_reset_o <= 1'b0;
		else if (running_o && ((dec_tick && count_o == '0) || (refresh_i && refresh_bad)))
			sys_reset_o <= 1'b1;
	end

endmodule : indwd_core

// *** sim/indwd_checker.sv ***
// Assertion checker on the watchdog register slave ports
`timescale 1ns/1ps
module indwd_checker (
	input  wire logic                        clk_i,
	input  wire logic                        resetn_i,
	input  wire logic                        s_axi_awvalid_i,
	input  wire logic                        s_axi_awready_o,
	input  wire logic                        s_axi_wvalid_i,
	input  wire logic                        s_axi_wready_o,
	input  wire logic [1:0]                  s_axi_bresp_o,
	input  wire logic                        s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic                        s_axi_arvalid_i,
	input  wire logic                        s_axi_arready_o,
	input  wire logic [31:0]                 s_axi_rdata_o,
	input  wire logic                        s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	input  wire logic                        sys_reset_o,
	input  wire logic                        running_o,
	input  wire logic [indwd_pkg::CNT_W-1:0] count_o
);
	import indwd_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	chk_write_answer: assert property (wr_taken |=> ##[0:1] s_axi_bvalid_o)
		else $error("write answer missing");
	chk_read_answer: assert property (rd_taken |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read answer missing");
	chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped");
	chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped");
	chk_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:12] == 20'h0)
		else $error("reserved bits read nonzero");
	chk_addr_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted while answering");
	chk_reset_sticky: assert property (sys_reset_o |=> sys_reset_o)
		else $error("system reset dropped");
	chk_run_sticky: assert property (running_o |=> running_o[*4])
		else $error("watchdog stopped");
	chk_idle_count: assert property (!running_o |-> count_o == 12'hfff && !sys_reset_o)
		else $error("idle counter wrong");
endmodule : indwd_checker

// *** sim/tb_top.sv ***
// Self-checking bench for the watchdog register slave
`timescale 1ns/1ps
module tb_top;
	import indwd_pkg::*;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        standby_i = 1'b0;
	logic [2:0]  lcnt = 3'h0;
	wire logic   low_speed_oscillator_clock_i = lcnt[2];
	logic [7:0]  s_axi_awaddr_i = 8'h0;
	logic [7:0]  s_axi_araddr_i = 8'h0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'h0;
	logic        s_axi_awvalid_i = 1'b0;
	logic        s_axi_wvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0;
	logic        s_axi_rready_i = 1'b0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic        sys_reset_o, running_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o;
	logic [11:0] count_o, rl;
	logic [33:0] exp_q[$];
	int          num_errors = 0;
	int          compares = 0;
	int          div[8] = '{4, 8, 16, 32, 64, 256, 256, 256};
	int          n;
	wire logic [5:0] flags = {count_o < 12'h20, sys_reset_o, s_axi_rvalid_o, s_axi_arready_o, s_axi_bvalid_o,
		s_axi_awready_o};

	indwd_regs i_indwd_regs (.*);

	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) lcnt <= lcnt + 3'h1;

	task automatic complete_run();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// Results are compared against the oldest note
	always @(posedge clk_i)
	begin
		if (s_axi_bvalid_o && s_axi_bready_i)
			cmp({s_axi_bresp_o, 32'h0}, exp_q.pop_front());
		if (s_axi_rvalid_o && s_axi_rready_i)
			cmp({s_axi_rresp_o, s_axi_rdata_o}, exp_q.pop_front());
	end

	task automatic wait_for(input int k, input int lim);
		int i;
		i = 0;
		@(posedge clk_i);
		while (!flags[k] && i < lim)
		begin
			@(posedge clk_i);
			i++;
		end
		if (i >= lim)
		begin
			num_errors++;
			complete_run();
		end
	endtask : wait_for

	// Each channel is released at the edge it is taken; bready comes after a random delay
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		int i;
		int dly;
		exp_q.push_back({r, 32'h0});
		dly = $urandom % 4;
		i = 0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= s;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= (dly == 0);
		do
		begin
			@(posedge clk_i);
			i++;
			if (s_axi_awvalid_i && s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
			if (i == dly)
				s_axi_bready_i <= 1'b1;
		end
		while (!(s_axi_bvalid_o && s_axi_bready_i) && i < 50);
		s_axi_bready_i <= 1'b0;
		@(posedge clk_i);
		if (i >= 50)
		begin
			num_errors++;
			complete_run();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		int dly;
		exp_q.push_back({r, d});
		dly = $urandom % 4;
		i = 0;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= (dly == 0);
		do
		begin
			@(posedge clk_i);
			i++;
			if (s_axi_arvalid_i && s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
			if (i == dly)
				s_axi_rready_i <= 1'b1;
		end
		while (!(s_axi_rvalid_o && s_axi_rready_i) && i < 50);
		s_axi_rready_i <= 1'b0;
		@(posedge clk_i);
		if (i >= 50)
		begin
			num_errors++;
			complete_run();
		end
	endtask : rd

	task automatic key(input logic [15:0] k);
		wr(OFS_KEY, {16'h0, k}, 4'hf, RESP_OKAY);
	endtask : key

	task automatic restart(input logic [11:0] window_limit);
		resetn_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		key(KEY_UNLOCK);
		wr(OFS_RELOAD, {20'h0, rl}, 4'hf, RESP_OKAY);
		repeat (40) @(posedge clk_i);
		key(KEY_START);
		key(KEY_UNLOCK);
		wr(OFS_WINDOW, {20'h0, window_limit}, 4'hf, RESP_OKAY);
		wr(OFS_WINDOW, 32'h30, 4'hf, RESP_OKAY);
		repeat (40) @(posedge clk_i);
		rd(OFS_WINDOW, {20'h0, window_limit}, RESP_OKAY);
	endtask : restart

	task automatic wait_chg();
		logic [11:0] c0;
		c0 = count_o;
		n = 0;
		while (count_o === c0 && n < 4000)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 4000)
		begin
			num_errors++;
			complete_run();
		end
	endtask : wait_chg

	initial
	begin
		void'($urandom(15408));
		rl = 12'h040 + 12'($urandom % 64);
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(OFS_KEY, 32'h0, RESP_OKAY);
		rd(OFS_PRESCALE, 32'h0, RESP_OKAY);
		rd(OFS_RELOAD, 32'hfff, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		rd(OFS_WINDOW, 32'hfff, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(8'h14, 32'h0, 4'hf, RESP_SLVERR);
		wr(OFS_RELOAD, {20'h0, rl}, 4'hf, RESP_OKAY);
		rd(OFS_RELOAD, 32'hfff, RESP_OKAY);
		wr(OFS_KEY, {16'h0, KEY_UNLOCK}, 4'h3, RESP_OKAY);
		wr(OFS_RELOAD, {20'h0, rl}, 4'h3, RESP_OKAY);
		wr(OFS_RELOAD, 32'h123, 4'hf, RESP_OKAY);
		rd(OFS_STATUS, 32'h2, RESP_OKAY);
		repeat (40) @(posedge clk_i);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		rd(OFS_RELOAD, {20'h0, rl}, RESP_OKAY);
		key(KEY_REFRESH);
		wr(OFS_WINDOW, 32'h20, 4'hf, RESP_OKAY);
		rd(OFS_WINDOW, 32'hfff, RESP_OKAY);
		cmp({33'h0, running_o}, 34'h0);
		key(KEY_START);
		cmp({33'h0, running_o}, 34'h1);
		cmp({33'h0, count_o >= 12'hffe}, 34'h1);
		for (int c = 7; c >= 0; c--)
		begin
			key(KEY_UNLOCK);
			wr(OFS_PRESCALE, c, 4'hf, RESP_OKAY);
			repeat (40) @(posedge clk_i);
			rd(OFS_PRESCALE, c, RESP_OKAY);
			key(KEY_REFRESH);
			cmp({33'h0, count_o <= rl && count_o + 12'h1 >= rl}, 34'h1);
			wait_chg();
			wait_chg();
			cmp(34'(n), 34'(div[c] * 8));
		end
		wait_for(4, 6000);
		cmp({22'h0, count_o}, 34'h0);
		restart(12'h020);
		cmp({33'h0, count_o <= rl && count_o + 12'h2 >= rl}, 34'h1);
		key(KEY_REFRESH);
		wait_for(4, 10);
		restart(12'h020);
		wait_for(5, 5000);
		key(KEY_REFRESH);
		repeat (8) @(posedge clk_i);
		cmp({33'h0, sys_reset_o}, 34'h0);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		key(KEY_UNLOCK);
		standby_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		standby_i <= 1'b0;
		wr(OFS_RELOAD, 32'h10, 4'hf, RESP_OKAY);
		rd(OFS_RELOAD, 32'hfff, RESP_OKAY);
		rd(OFS_WINDOW, 32'hfff, RESP_OKAY);
		cmp({33'h0, running_o}, 34'h1);
		complete_run();
	end
endmodule : tb_top

bind indwd_regs indwd_checker i_indwd_checker (.*);
